/* File: logic/port_bank.sv */
// six ports (low port open-drain, the other five quasi-bidirectional), one input-only port, bus switching of two ports
// assumes the cpu core drives the strobes, bus data and mode controls on clk_i
// How it works
// - six 8-bit ports: latch, driver, input buffer
// - low port drives address then data
// - high port: address if 16-bit, else latch
// - input-only port reads all eight lines
// - channel select field; analog bits undetermined
// - latch write, latch read, pin read strobes
// - latch one means weak pullup input
// - zero-to-one: strong pullup for two phases
// - low port pullup only in bus mode
// - low port latch one floats pin
// - bus mode from access pin, counter or external cycle
// - bus mode: high kept; external cycle: low latch ones
// - 16-bit: high port strong pullup whole cycle
// - alternate function passes only when latch one
// - multifunction bit order: serial, ints, counters, strobes
// - latch at state6 phase2, pin at state1 phase1
// - buffers sample latch in phase 1 only
// - reset sets all latches to ones
// - read-modify-write reads latch, others pin
`timescale 1ns/1ps
module port_bank #(
    parameter int NPORT = port_bank_pkg::NUM_PORTS,
    parameter logic [15:0] INT_ROM_TOP = 16'h0fff
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    // cpu side
    input wire logic [2:0] port_sel_i,
    input wire logic latch_write_i,
    input wire logic [7:0] write_data_i,
    input wire port_bank_pkg::read_sel_t read_sel_i,
    input wire logic rmw_i,
    output logic [7:0] read_data_o,
    // external memory control
    input wire logic external_access_select_n_i,
    input wire logic [15:0] program_counter_i,
    input wire logic ext_cycle_i,
    input wire logic addr16_i,
    input wire logic addr_phase_i,
    input wire logic data_drive_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic [7:0] bus_wdata_i,
    output logic [7:0] bus_rdata_o,
    output logic bus_mode_o,
    // input-only port and converter control
    input wire logic [7:0] input_only_pins_i,
    input wire logic [7:0] converter_control_reg_i,
    output logic [7:0] input_only_port_value_o,
    output logic [2:0] analog_channel_o,
    // multifunction peripheral side
    input wire logic ser_tx_i,
    input wire logic write_strobe_n_i,
    input wire logic read_strobe_n_i,
    output logic ser_rx_o,
    output logic external_interrupt_zero_o,
    output logic external_interrupt_one_o,
    output logic counter_input_zero_o,
    output logic counter_input_one_o,
    // pins: flattened NPORT*8; drive low when pull_low_n is low
    input wire logic [NPORT*8-1:0] pin_i,
    output logic [NPORT*8-1:0] pull_low_n_o,
    output logic [NPORT*8-1:0] weak_up_o,
    output logic [NPORT*8-1:0] strong_up_o
);
    logic [NPORT*8-1:0] pin_s1_q;
    logic [NPORT*8-1:0] pin_s2_q;
    logic [7:0] ain_s1_q;
    logic [7:0] ain_s2_q;
    logic [NPORT*8-1:0] latch_q;
    logic [NPORT*8-1:0] latch_d;
    logic [NPORT*8-1:0] buf_q;
    logic [NPORT*8-1:0] buf_d;
    logic [NPORT*8-1:0] boost_q;
    logic [NPORT*8-1:0] boost_d;
    logic [7:0] read_d;
    logic [7:0] read_q;
    logic [7:0] pend_data_q;
    logic [7:0] pend_data_d;
    logic [2:0] pend_sel_q;
    logic [2:0] pend_sel_d;
    logic pend_q;
    logic pend_d;
    logic bus_mode;
    logic [7:0] mf_out;

    phase_if ph ();

    phase_seq u_seq (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ph(ph.seq)
    );

    function automatic logic [7:0] port_slice(input logic [NPORT*8-1:0] v, input int p);
        port_slice = v[p*8 +: 8];
    endfunction : port_slice

    assign bus_mode = !external_access_select_n_i || (program_counter_i > INT_ROM_TOP)
        || ext_cycle_i;
    assign bus_mode_o = bus_mode;

    // pins come from outside the clock domain
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pin_s1_q <= '1;
            pin_s2_q <= '1;
            ain_s1_q <= 8'h00;
            ain_s2_q <= 8'h00;
        end else begin
            pin_s1_q <= pin_i;
            pin_s2_q <= pin_s1_q;
            ain_s1_q <= input_only_pins_i;
            ain_s2_q <= ain_s1_q;
        end
    end

    // latch writes wait for state6 phase2, the moment the cpu delivers them
    always_comb begin
        latch_d = latch_q;
        pend_d = pend_q;
        pend_data_d = pend_data_q;
        pend_sel_d = pend_sel_q;
        if (latch_write_i) begin
            pend_d = 1'b1;
            pend_data_d = write_data_i;
            pend_sel_d = port_sel_i;
        end
        if (pend_q && ph.state6_phase2) begin
            for (int p = 0; p < NPORT; p++) begin
                if (pend_sel_q == 3'(p)) begin
                    latch_d[p*8 +: 8] = pend_data_q;
                end
            end
            if (!latch_write_i) begin
                pend_d = 1'b0;
            end
        end
        if (ext_cycle_i) begin
            latch_d[port_bank_pkg::LOW_PORT*8 +: 8] = 8'hff;
        end
    end

    always_comb begin
        if (ph.phase1) begin
            buf_d = latch_q;
        end else begin
            buf_d = buf_q;
        end
    end

    // boost lasts the two phases after the buffer rises at state1
    always_comb begin
        boost_d = '0;
        if (ph.state1_phase1) begin
            boost_d = latch_q & ~buf_q;
        end else if (ph.phase1 == 1'b0 && boost_q != '0) begin
            boost_d = boost_q;
        end
    end

    always_comb begin
        read_d = read_q;
        if (read_sel_i != port_bank_pkg::READ_NONE) begin
            if (port_sel_i == 3'(NPORT)) begin
                read_d = ain_s2_q;
            end else if (read_sel_i == port_bank_pkg::READ_LATCH || rmw_i) begin
                read_d = port_slice(latch_q, int'(port_sel_i));
            end else begin
                read_d = port_slice(pin_s2_q, int'(port_sel_i));
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            latch_q <= {NPORT{port_bank_pkg::LATCH_RESET}};
            buf_q <= {NPORT{port_bank_pkg::LATCH_RESET}};
            boost_q <= '0;
            read_q <= 8'h00;
            pend_q <= 1'b0;
            pend_data_q <= 8'h00;
            pend_sel_q <= 3'h0;
        end else begin
            latch_q <= latch_d;
            buf_q <= buf_d;
            boost_q <= boost_d;
            read_q <= read_d;
            pend_q <= pend_d;
            pend_data_q <= pend_data_d;
            pend_sel_q <= pend_sel_d;
        end
    end

    assign read_data_o = read_q;
    assign input_only_port_value_o = ain_s2_q;
    // analog-used bits read undetermined; software masks them
    assign analog_channel_o = converter_control_reg_i[port_bank_pkg::CHAN_W-1:0];
    assign bus_rdata_o = port_slice(pin_s2_q, port_bank_pkg::LOW_PORT);

    // alternate outputs gated by latch one
    always_comb begin
        mf_out = 8'hff;
        mf_out[port_bank_pkg::SER_TX_BIT] = ser_tx_i;
        mf_out[port_bank_pkg::WR_STROBE_BIT] = write_strobe_n_i;
        mf_out[port_bank_pkg::RD_STROBE_BIT] = read_strobe_n_i;
    end

    // pin reads zero when latch holds zero, so inputs pass only when it holds one
    assign ser_rx_o = pin_s2_q[port_bank_pkg::MULTI_PORT*8 + port_bank_pkg::SER_RX_BIT];
    assign external_interrupt_zero_o =
        pin_s2_q[port_bank_pkg::MULTI_PORT*8 + port_bank_pkg::INT_ZERO_BIT];
    assign external_interrupt_one_o =
        pin_s2_q[port_bank_pkg::MULTI_PORT*8 + port_bank_pkg::INT_ONE_BIT];
    assign counter_input_zero_o =
        pin_s2_q[port_bank_pkg::MULTI_PORT*8 + port_bank_pkg::CNT_ZERO_BIT];
    assign counter_input_one_o =
        pin_s2_q[port_bank_pkg::MULTI_PORT*8 + port_bank_pkg::CNT_ONE_BIT];

    always_comb begin
        logic [7:0] v;
        v = 8'h00;
        pull_low_n_o = '1;
        weak_up_o = '0;
        strong_up_o = '0;
        for (int p = 0; p < NPORT; p++) begin
            v = buf_q[p*8 +: 8];
            if (p == port_bank_pkg::LOW_PORT) begin
                if (bus_mode && (addr_phase_i || data_drive_i)) begin
                    v = addr_phase_i ? bus_addr_i[7:0] : bus_wdata_i;
                    pull_low_n_o[p*8 +: 8] = v;
                    strong_up_o[p*8 +: 8] = v;
                end else begin
                    pull_low_n_o[p*8 +: 8] = v;
                end
            end else begin
                if (p == port_bank_pkg::HIGH_PORT && bus_mode && addr16_i) begin
                    v = bus_addr_i[15:8];
                    strong_up_o[p*8 +: 8] = v;
                end else begin
                    if (p == port_bank_pkg::MULTI_PORT) begin
                        v = v & mf_out;
                    end
                    strong_up_o[p*8 +: 8] = boost_q[p*8 +: 8] & v;
                end
                pull_low_n_o[p*8 +: 8] = v;
                weak_up_o[p*8 +: 8] = v;
            end
        end
    end
endmodule : port_bank

/* File: pkg/port_bank_pkg.sv */
// constants and types shared by the port bank and its phase sequencer
// assumes one system clock; each clock is one oscillator phase of the cpu
package port_bank_pkg;
    localparam int NUM_PORTS = 6;
    localparam int PORT_W = 8;
    localparam logic [7:0] LATCH_RESET = 8'hff;
    localparam int PHASES_PER_CYCLE = 12;
    localparam logic [3:0] STATE1_PHASE1 = 4'h0;
    localparam logic [3:0] STATE1_PHASE2 = 4'h1;
    localparam logic [3:0] STATE6_PHASE2 = 4'hb;
    localparam int LOW_PORT = 0;
    localparam int HIGH_PORT = 2;
    localparam int MULTI_PORT = 3;
    localparam int CHAN_W = 3;
    // multifunction port bit positions
    localparam int SER_RX_BIT = 0;
    localparam int SER_TX_BIT = 1;
    localparam int INT_ZERO_BIT = 2;
    localparam int INT_ONE_BIT = 3;
    localparam int CNT_ZERO_BIT = 4;
    localparam int CNT_ONE_BIT = 5;
    localparam int WR_STROBE_BIT = 6;
    localparam int RD_STROBE_BIT = 7;
    typedef enum logic [1:0] {
        READ_NONE = 2'b00,
        READ_LATCH = 2'b01,
        READ_PIN = 2'b10
    } read_sel_t;
endpackage : port_bank_pkg

/* File: pkg/phase_if.sv */
// carries the machine-cycle phase timing from the sequencer to the port bank
// assumes a single clock domain
`timescale 1ns/1ps
interface phase_if;
    logic phase1;
    logic state1_phase1;
    logic state6_phase2;
    modport seq (output phase1, output state1_phase1, output state6_phase2);
    modport user (input phase1, input state1_phase1, input state6_phase2);
endinterface : phase_if

/* File: logic/phase_seq.sv */
// machine-cycle phase counter: twelve phases, six states of two phases
// assumes clk_i is the oscillator phase clock
`timescale 1ns/1ps
module phase_seq (
    input wire logic clk_i,
    input wire logic resetn_i,
    phase_if.seq ph
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;

    always_comb begin
        if (cnt_q == 4'(port_bank_pkg::PHASES_PER_CYCLE - 1)) begin
            cnt_d = 4'h0;
        end else begin
            cnt_d = cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign ph.phase1 = ~cnt_q[0];
    assign ph.state1_phase1 = (cnt_q == port_bank_pkg::STATE1_PHASE1);
    assign ph.state6_phase2 = (cnt_q == port_bank_pkg::STATE6_PHASE2);
endmodule : phase_seq

/* File: test/port_bank_checker.sv */
// checker on the port bank top ports
// assumes its phase count restarts at zero with reset, as the sequencer does
`timescale 1ns/1ps
module port_bank_checker #(
    parameter int NPORT = 6,
    parameter logic [15:0] INT_ROM_TOP = 16'h0fff
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic external_access_select_n_i,
    input wire logic [15:0] program_counter_i,
    input wire logic ext_cycle_i,
    input wire logic ser_tx_i,
    input wire logic [7:0] input_only_pins_i,
    input wire logic [7:0] converter_control_reg_i,
    input wire logic bus_mode_o,
    input wire logic [7:0] input_only_port_value_o,
    input wire logic [2:0] analog_channel_o,
    input wire logic ser_rx_o,
    input wire logic [NPORT*8-1:0] pull_low_n_o,
    input wire logic [NPORT*8-1:0] weak_up_o,
    input wire logic [NPORT*8-1:0] strong_up_o
);
    logic [3:0] ph_q, ph_d;
    logic [1:0] up_q, up_d;
    always_comb begin
        ph_d = (ph_q == 4'hb) ? 4'h0 : ph_q + 4'h1;
        up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
        if (!resetn_i) begin
            ph_d = 4'h0;
            up_d = 2'h0;
        end
    end
    always_ff @(posedge clk_i) begin
        ph_q <= ph_d;
        up_q <= up_d;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // two phases high then off: shorter kicks leave slow edges
    sequence strong_pulse;
        strong_up_o[8] ##1 !strong_up_o[8];
    endsequence
    AST_ANALOG: assert property (analog_channel_o == converter_control_reg_i[2:0])
        else $error("analog channel differs from control bits");
    AST_RESET: assert property ($rose(resetn_i) |-> &pull_low_n_o && &weak_up_o[47:8])
        else $error("pins not released after reset");
    AST_BUSMODE: assert property
        (bus_mode_o == (!external_access_select_n_i || program_counter_i > INT_ROM_TOP
            || ext_cycle_i))
        else $error("bus mode wrong");
    AST_LOWFLOAT: assert property
        ((!bus_mode_o) [*3] |-> weak_up_o[7:0] == 8'h00 && strong_up_o[7:0] == 8'h00)
        else $error("low port pulled up outside bus mode");
    AST_RXGATE: assert property ((!pull_low_n_o[24]) [*4] |-> !ser_rx_o)
        else $error("receive input passed while pulled low");
    AST_TXALT: assert property ((!ser_tx_i) [*4] |-> !pull_low_n_o[25])
        else $error("transmit output not on its pin");
    AST_STRONG: assert property ($rose(strong_up_o[8]) |-> ph_q <= 4'h2 ##1 strong_pulse)
        else $error("strong pullup pulse wrong");
    AST_PINTIME: assert property ($changed(pull_low_n_o[15:8]) |-> ph_q <= 4'h1)
        else $error("pin changed outside first state");
    AST_INONLY: assert property
        (up_q == 2'h3 |-> input_only_port_value_o == $past(input_only_pins_i, 2))
        else $error("input-only value not the synced lines");
endmodule : port_bank_checker
bind port_bank port_bank_checker #(.NPORT(NPORT), .INT_ROM_TOP(INT_ROM_TOP)) port_bank_checker_i (
    .clk_i, .resetn_i, .external_access_select_n_i, .program_counter_i, .ext_cycle_i, .ser_tx_i,
    .input_only_pins_i, .converter_control_reg_i, .bus_mode_o, .input_only_port_value_o,
    .analog_channel_o, .ser_rx_o, .pull_low_n_o, .weak_up_o, .strong_up_o);

/* File: test/pin_env.sv */
// external pins: resolves each level from the drive enables and outside pulls
// assumes nothing outside drives high; an undriven pin toggles every cycle
`timescale 1ns/1ps
module pin_env (
    input wire logic clk_i,
    input wire logic [47:0] pull_low_n_i,
    input wire logic [47:0] weak_up_i,
    input wire logic [47:0] strong_up_i,
    input wire logic [47:0] ext_low_i,
    output logic [47:0] pin_o
);
    logic tog_q = 1'b0;
    always_ff @(posedge clk_i) begin
        tog_q <= !tog_q;
    end
    always_comb begin
        for (int b = 0; b < 48; b++) begin
            // a floating pin holds no value, so never echo the last one
            pin_o[b] = (!pull_low_n_i[b] || ext_low_i[b]) ? 1'b0 :
                (weak_up_i[b] || strong_up_i[b]) ? 1'b1 : tog_q;
        end
    end
endmodule : pin_env

/* File: test/port_bank_tb.sv */
// bench for the port bank: latch strobes, pin reads, alternate and bus use
// assumes pin_env stands for the board around the pins
`timescale 1ns/1ps
module port_bank_tb;
    logic clk_i = 1'b0, resetn_i = 1'b0, latch_write_i = 1'b0, rmw_i = 1'b0;
    logic [2:0] port_sel_i = 3'h0;
    logic [7:0] write_data_i = 8'h00, bus_wdata_i = 8'ha3, converter_control_reg_i = 8'h00;
    port_bank_pkg::read_sel_t read_sel_i = port_bank_pkg::READ_NONE;
    logic external_access_select_n_i = 1'b1, ext_cycle_i = 1'b0, addr16_i = 1'b0;
    logic addr_phase_i = 1'b0, data_drive_i = 1'b0, ser_tx_i = 1'b1;
    logic [15:0] program_counter_i = 16'h0000, bus_addr_i = 16'h7e5c;
    logic [7:0] input_only_pins_i = 8'ha5, read_data_o, input_only_port_value_o;
    logic [2:0] analog_channel_o;
    logic bus_mode_o, ser_rx_o, external_interrupt_zero_o, external_interrupt_one_o;
    logic write_strobe_n_i = 1'b1, read_strobe_n_i = 1'b1;
    logic [7:0] bus_rdata_o;
    logic counter_input_zero_o, counter_input_one_o;
    logic [47:0] pin_i, pull_low_n_o, weak_up_o, strong_up_o, ext_low = '0;
    int mismatches = 0, tests_run = 0;
    port_bank #(.INT_ROM_TOP(16'h0fff)) port_bank_i (.clk_i, .resetn_i, .port_sel_i,
        .latch_write_i, .write_data_i, .read_sel_i, .rmw_i, .read_data_o,
        .external_access_select_n_i, .program_counter_i, .ext_cycle_i, .addr16_i,
        .addr_phase_i, .data_drive_i, .bus_addr_i, .bus_wdata_i, .bus_rdata_o,
        .bus_mode_o, .input_only_pins_i, .converter_control_reg_i,
        .input_only_port_value_o, .analog_channel_o, .ser_tx_i,
        .write_strobe_n_i, .read_strobe_n_i, .ser_rx_o,
        .external_interrupt_zero_o, .external_interrupt_one_o, .counter_input_zero_o,
        .counter_input_one_o, .pin_i, .pull_low_n_o, .weak_up_o, .strong_up_o);
    pin_env pin_env_i (.clk_i, .pull_low_n_i(pull_low_n_o), .weak_up_i(weak_up_o),
        .strong_up_i(strong_up_o), .ext_low_i(ext_low), .pin_o(pin_i));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    // new value lands at the end of the machine cycle, so wait fifteen phases, over one whole cycle
    task automatic write_port(input logic [2:0] p, input logic [7:0] d);
        port_sel_i <= p;
        write_data_i <= d;
        latch_write_i <= 1'b1;
        tick(1);
        latch_write_i <= 1'b0;
        tick(14);
    endtask : write_port
    task automatic read_port(input logic [2:0] p, input port_bank_pkg::read_sel_t s,
            input logic m, input logic [7:0] exp);
        port_sel_i <= p;
        read_sel_i <= s;
        rmw_i <= m;
        tick(1);
        read_sel_i <= port_bank_pkg::READ_NONE;
        rmw_i <= 1'b0;
        tick(1);
        check(read_data_o, exp);
    endtask : read_port
    initial begin
        tick(20000);
        mismatches++;
        complete_run();
    end
    initial begin
        tick(4);
        resetn_i <= 1'b1;
        tick(2);
        for (int p = 0; p < 6; p++) read_port(p[2:0], port_bank_pkg::READ_LATCH, 1'b0, 8'hff);
        for (int p = 1; p < 6; p++) read_port(p[2:0], port_bank_pkg::READ_PIN, 1'b0, 8'hff);
        read_port(3'h6, port_bank_pkg::READ_PIN, 1'b0, 8'ha5);
        write_port(3'h1, 8'h5a);
        read_port(3'h1, port_bank_pkg::READ_LATCH, 1'b0, 8'h5a);
        check(pull_low_n_o[15:8], 8'h5a);
        ext_low[9] <= 1'b1;
        tick(4);
        read_port(3'h1, port_bank_pkg::READ_PIN, 1'b0, 8'h58);
        read_port(3'h1, port_bank_pkg::READ_PIN, 1'b1, 8'h5a);
        ext_low <= '0;
        write_port(3'h1, 8'hff);
        check(weak_up_o[15:8], 8'hff);
        ext_low[31:24] <= 8'h15;
        ser_tx_i <= 1'b0;
        write_strobe_n_i <= 1'b0;
        tick(5);
        check({counter_input_one_o, counter_input_zero_o, external_interrupt_one_o,
            external_interrupt_zero_o, ser_rx_o}, 5'b10100);
        check(pull_low_n_o[25], 1'b0);
        check(pull_low_n_o[31:24], 8'hbd);
        ser_tx_i <= 1'b1;
        write_strobe_n_i <= 1'b1;
        ext_low <= '0;
        write_port(3'h3, 8'h00);
        // pin levels reach the alternate inputs two flops after the driver moves
        tick(2);
        check({counter_input_one_o, ser_rx_o, pull_low_n_o[31:24]}, 10'h000);
        write_port(3'h0, 8'h3c);
        write_port(3'h2, 8'h81);
        program_counter_i <= 16'h1000;
        ext_cycle_i <= 1'b1;
        addr16_i <= 1'b1;
        addr_phase_i <= 1'b1;
        tick(5);
        check(bus_mode_o, 1'b1);
        check({pull_low_n_o[23:16], strong_up_o[23:16]}, 16'h7e7e);
        check(pull_low_n_o[7:0], 8'h5c);
        addr_phase_i <= 1'b0;
        data_drive_i <= 1'b1;
        addr16_i <= 1'b0;
        tick(5);
        check({pull_low_n_o[23:16], pull_low_n_o[7:0]}, 16'h81a3);
        check(bus_rdata_o, 8'ha3);
        ext_cycle_i <= 1'b0;
        data_drive_i <= 1'b0;
        program_counter_i <= 16'h0fff;
        tick(14);
        check({bus_mode_o, pull_low_n_o[23:16], weak_up_o[7:0]}, 17'h08100);
        read_port(3'h0, port_bank_pkg::READ_LATCH, 1'b0, 8'hff);
        read_port(3'h2, port_bank_pkg::READ_LATCH, 1'b0, 8'h81);
        external_access_select_n_i <= 1'b0;
        converter_control_reg_i <= 8'h0d;
        tick(1);
        check({bus_mode_o, analog_channel_o}, 4'hd);
        input_only_pins_i <= 8'h96;
        tick(3);
        check(input_only_port_value_o, 8'h96);
        read_port(3'h6, port_bank_pkg::READ_PIN, 1'b0, 8'h96);
        complete_run();
    end
endmodule : port_bank_tb
